// ===== design/nbi_host.v
// Host controller driving the NAND flash asynchronous multiplexed bus.
`timescale 1ns/1ps
`default_nettype none
`include "nbi_map.vh"
module nbi_host (
	input  wire        mclk_i,          // System clock, 20 MHz.
	input  wire        rst_i,           // Synchronous reset, active high.
	input  wire        wide_i,          // High for the 16-bit part.
	input  wire        req_valid_i,     // Request strobe for one bus cycle.
	input  wire [1:0]  req_op_i,        // Cycle kind.
	input  wire [15:0] req_data_i,      // Command byte or write word.
	input  wire [11:0] addr_column_i,   // Column field for address sequence.
	input  wire [5:0]  addr_page_i,     // Page field.
	input  wire [16:0] addr_block_i,    // Block field, bit 6 selects the plane.
	input  wire        deselect_i,      // Request to raise chip select.
	input  wire        guard_i,         // Write guard level wanted on the pin.
	input  wire [15:0] io_in_i,         // Data lines as seen at the pins.
	input  wire        ready_busy_n_i,  // Ready-busy pin, low while busy.
	output reg         req_ready_o,     // High when a request may be taken.
	output reg         rsp_valid_o,     // One-cycle pulse with read data.
	output reg  [15:0] rsp_data_o,      // Read word.
	output reg         chip_select_n_o, // Chip select, active low.
	output reg         command_latch_strobe_o,
	output reg         address_latch_strobe_o,
	output reg         write_strobe_n_o,
	output reg         read_strobe_n_o,
	output reg         write_guard_n_o, // Low refuses program and erase.
	output reg  [15:0] io_out_o,        // Data lines driven value.
	output reg         io_oe_o,         // High while the host drives the lines.
	output reg         busy_o,          // Synchronised ready-busy, high when busy.
	output reg         status_mode_o    // High after a status read command.
);
	// Each bus cycle is built from whole clocks: the write strobe is low for one
	// clock and high for one, while the read strobe is low for three so that the
	// answer has cleared the input flops before it is taken.
	// Chip select stays low after a request until the user asks for deselect,
	// so back-to-back cycles need no fresh selection.
	// Limitation: latch strobes and chip select change on the clock that lowers
	// the write strobe, so set-up ahead of that edge is left to board delays.
	// The host does no busy filtering; the user watches busy_o for that.
	// State codes.
	localparam ST_IDLE = 2'h0;
	localparam ST_LOW  = 2'h1;
	localparam ST_HIGH = 2'h2;
	localparam ST_ADDR = 2'h3;

	reg [1:0]  state;       // Current state.
	reg [1:0]  op;          // Latched cycle kind.
	reg [2:0]  acnt;        // Address cycle index.
	reg [39:0] aword;       // Packed five address bytes.
	reg        rb_meta;     // First synchroniser stage for ready-busy.
	reg        rb_sync;     // Second stage.
	reg [15:0] io_meta;     // First synchroniser stage for data lines.
	reg [15:0] io_sync;     // Second stage.
	reg [1:0]  hcnt;        // Half-cycle counter.
	reg [39:0] next_aword;  // Address bytes built from the fields.
	reg [11:0] col;         // Column with out-of-space bits forced low.

	// Build the five address bytes; out-of-space bits are zero.
	always @* begin
		col = addr_column_i;
		if (wide_i) begin
			col[11] = 1'b0;
			if (col[10])
				col[9:5] = 5'h00;
		end else if (col[11]) begin
			col[10:6] = 5'h00;
		end
		next_aword[7:0]   = col[7:0];
		next_aword[15:8]  = {4'h0, col[11:8]};
		// Row is block over page, low block bits share the third byte.
		next_aword[23:16] = {addr_block_i[7:6], addr_page_i};
		next_aword[31:24] = addr_block_i[15:8];
		next_aword[39:32] = {7'h00, addr_block_i[16]};
	end

	// Pin inputs pass two flops before any logic reads them.
	// The data word is only taken while the die holds it steady, so bit skew is harmless.
	always @(posedge mclk_i) begin
		rb_meta <= ready_busy_n_i;
		rb_sync <= rb_meta;
		io_meta <= io_in_i;
		io_sync <= io_meta;
	end

	// Main sequencer; one strobe cycle is a low half then a high half.
	always @(posedge mclk_i) begin
		rsp_valid_o <= 1'b0;
		busy_o <= ~rb_sync;
		write_guard_n_o <= guard_i;
		if (rst_i) begin
			state <= ST_IDLE;
			op <= `NBI_OP_CMD;
			acnt <= 3'h0;
			aword <= 40'h0;
			hcnt <= 2'h0;
			req_ready_o <= 1'b0;
			rsp_data_o <= 16'h0000;
			chip_select_n_o <= 1'b1;
			command_latch_strobe_o <= 1'b0;
			address_latch_strobe_o <= 1'b0;
			write_strobe_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			io_out_o <= 16'h0000;
			io_oe_o <= 1'b0;
			status_mode_o <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				req_ready_o <= 1'b1;
				command_latch_strobe_o <= 1'b0;
				address_latch_strobe_o <= 1'b0;
				io_oe_o <= 1'b0;
				if (deselect_i) begin
					chip_select_n_o <= 1'b1;
				end
				if (req_valid_i && req_ready_o) begin
					req_ready_o <= 1'b0;
					chip_select_n_o <= 1'b0;
					op <= req_op_i;
					hcnt <= 2'h0;
					// Latch strobes are exclusive; read strobe stays high on writes.
					command_latch_strobe_o <= (req_op_i == `NBI_OP_CMD);
					address_latch_strobe_o <= (req_op_i == `NBI_OP_ADDR);
					if (req_op_i == `NBI_OP_READ) begin
						read_strobe_n_o <= 1'b0;
					end else begin
						write_strobe_n_o <= 1'b0;
						io_oe_o <= 1'b1;
					end
					case (req_op_i)
					`NBI_OP_CMD: begin
						io_out_o <= {8'h00, req_data_i[7:0]};
						// Status reads are the only commands a busy die takes.
						// Any other command, the return-to-data one included, ends status mode,
						// so the user can see when array data may be read again.
						status_mode_o <= (req_data_i[7:0] == `NBI_STATUS_READ_CMD) ||
							(req_data_i[7:0] == `NBI_DIE_STATUS_READ_CMD);
					end
					`NBI_OP_ADDR: begin
						aword <= next_aword;
						acnt <= 3'h0;
						io_out_o <= {8'h00, next_aword[7:0]};
					end
					`NBI_OP_WRITE: begin
						// Narrow part uses the low lines only.
						io_out_o <= wide_i ? req_data_i : {8'h00, req_data_i[7:0]};
					end
					default: begin
						io_out_o <= 16'h0000;
					end
					endcase
					state <= ST_LOW;
				end
			end
			ST_LOW: begin
				hcnt <= hcnt + 2'h1;
				if (op == `NBI_OP_READ) begin
					// The die drives the word as soon as the read strobe falls, but the
					// word needs two clocks through the input flops, so the strobe is
					// held low for three clocks and the word is taken as it rises.
					// This keeps the read cycle well above the rising-edge threshold.
					if (hcnt + 2'h1 >= `NBI_READ_LOW_CYC) begin
						hcnt <= 2'h0;
						read_strobe_n_o <= 1'b1;
						// Narrow part uses the low lines only.
						rsp_data_o <= wide_i ? io_sync : {8'h00, io_sync[7:0]};
						rsp_valid_o <= 1'b1;
						state <= ST_HIGH;
					end
				end else if (hcnt + 2'h1 >= `NBI_HALF_CYC) begin
					hcnt <= 2'h0;
					// Rising write strobe latches command, address or data.
					write_strobe_n_o <= 1'b1;
					state <= (op == `NBI_OP_ADDR) ? ST_ADDR : ST_HIGH;
				end
			end
			ST_ADDR: begin
				// Hold the high half, then step to the next of five bytes.
				if (acnt == `NBI_ADDR_CYCLES - 3'h1) begin
					state <= ST_HIGH;
				end else begin
					acnt <= acnt + 3'h1;
					aword <= {8'h00, aword[39:8]};
					io_out_o <= {8'h00, aword[15:8]};
					write_strobe_n_o <= 1'b0;
					state <= ST_LOW;
				end
			end
			ST_HIGH: begin
				// Latch strobes and the lines are held one clock past the last
				// strobe rise, two after the fifth address byte, so the die still sees them steady at that edge.
				command_latch_strobe_o <= 1'b0;
				address_latch_strobe_o <= 1'b0;
				io_oe_o <= 1'b0;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== design/nbi_map.vh
// Constants for the NAND asynchronous bus host controller.
`ifndef NBI_MAP_VH
`define NBI_MAP_VH
// Op codes on the user command port.
`define NBI_OP_CMD        2'h0
`define NBI_OP_ADDR       2'h1
`define NBI_OP_WRITE      2'h2
`define NBI_OP_READ       2'h3
// Command byte values.
`define NBI_STATUS_READ_CMD     8'h70
`define NBI_DIE_STATUS_READ_CMD 8'h78
`define NBI_RETURN_TO_DATA_CMD  8'h00
// Strobe timing: each half cycle in ns, and in clocks at 50 ns per clock.
`define NBI_CLK_NS        50
`define NBI_HALF_NS       50
`define NBI_HALF_CYC      ((`NBI_HALF_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
// Clocks the read strobe stays low, so the word clears the two input flops.
`define NBI_READ_LOW_CYC  3
// Read cycle time threshold for latching on the rising read strobe edge.
`define NBI_RC_THRESH_NS  30
// Address cycle count and field positions.
`define NBI_ADDR_CYCLES   3'h5
`define NBI_PAGE_LSB      0
`define NBI_BLOCK_LSB     6
`endif

// ===== tb/nbi_dev_model.sv
// Behavioural model of one NAND die on the asynchronous bus.
`timescale 1ns/1ps
`default_nettype none
module nbi_dev_model (
	input  wire logic        cs_n,
	input  wire logic        cle,
	input  wire logic        ale,
	input  wire logic        we_n,
	input  wire logic        read_strobe_n,
	input  wire logic        oe_h,
	input  wire logic        busy,
	input  wire logic [15:0] io_h,
	output wire logic [15:0] pin,
	output wire logic        rb_n
);
	logic [15:0] cmd = '0, cache = '0, q = '0;
	logic [15:0] ab [0:4];
	logic        drv = 1'b0;
	integer      na = 0;
	// Released lines show the inverse of the last word, so a stale value never passes.
	assign pin = oe_h ? io_h : (drv ? q : ~q);
	assign rb_n = !busy;
	// Write strobe rise latches a command, an address byte or a data word.
	always @(posedge we_n) begin
		if (!cs_n && read_strobe_n && cle && !ale &&
			(!busy || io_h[7:0] == 8'h70 || io_h[7:0] == 8'h78)) begin
			cmd = io_h;
			na = 0;
		end else if (!cs_n && read_strobe_n && ale && !cle &&
			(!busy || cmd[7:0] == 8'h78) && na < 5) begin
			ab[na] = io_h;
			na++;
		end else if (!cs_n && read_strobe_n && !cle && !ale && !busy)
			cache = io_h;
	end
	// Read strobe fall drives the cache word; deselect or a write strobe releases the lines.
	always @(negedge read_strobe_n or posedge cs_n or negedge we_n) begin
		drv = !read_strobe_n && !cs_n && !cle && !ale && we_n && !busy;
		if (drv)
			q = cache;
	end
endmodule
`default_nettype wire

// ===== tb/nbi_host_asserts.sv
// Bus protocol checker for the NAND host controller.
`timescale 1ns/1ps
`default_nettype none
module nbi_host_chk (
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic        guard_i,
	input wire logic        ready_busy_n_i,
	input wire logic        rsp_valid_o,
	input wire logic        chip_select_n_o,
	input wire logic        command_latch_strobe_o,
	input wire logic        address_latch_strobe_o,
	input wire logic        write_strobe_n_o,
	input wire logic        read_strobe_n_o,
	input wire logic        write_guard_n_o,
	input wire logic        io_oe_o,
	input wire logic        busy_o,
	input wire logic [15:0] io_out_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_latch_exclusive: assert property (!(command_latch_strobe_o && address_latch_strobe_o))
		else $error("both latches high");
	a_write_read_high: assert property (!write_strobe_n_o |-> read_strobe_n_o)
		else $error("read low in write");
	a_cmd_upper_zero: assert property (command_latch_strobe_o && !write_strobe_n_o |-> io_oe_o && io_out_o[15:8] == 8'h00)
		else $error("command upper lines");
	a_addr_upper_zero: assert property (address_latch_strobe_o && !write_strobe_n_o |-> io_out_o[15:8] == 8'h00)
		else $error("address upper lines");
	a_strobe_selected: assert property (!write_strobe_n_o || !read_strobe_n_o |-> !chip_select_n_o)
		else $error("strobe while deselected");
	a_read_released: assert property (!read_strobe_n_o |-> !io_oe_o && !command_latch_strobe_o)
		else $error("host drives in read");
	a_read_answer: assert property ($rose(read_strobe_n_o) |-> ##[0:2] rsp_valid_o)
		else $error("no read answer");
	a_guard_follow: assert property (!$past(rst_i) |-> write_guard_n_o == $past(guard_i))
		else $error("guard pin lags");
	a_busy_seen: assert property (!ready_busy_n_i [*5] |-> busy_o)
		else $error("busy not seen");
	a_ale_hold: assert property ($rose(address_latch_strobe_o) |=> address_latch_strobe_o [*8])
		else $error("address latch dropped");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Testbench for the NAND host controller against a die model.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk_i, rst_i, wide, rv, desel, guard, dbusy;
	logic [1:0] op;
	logic [15:0] wd;
	logic [11:0] col;
	logic [5:0] pg;
	logic [16:0] blk;
	wire [15:0] pin, io_out, rsp;
	wire rb_n, rdy, rspv, cs_n, cle, ale, we_n, read_strobe_n, wg_n, oe, busy, stm;
	integer errors = 0, total_checks = 0;
	integer nrsp = 0;
	// Count read answers, so a missing or doubled pulse shows up.
	always @(posedge mclk_i)
		if (rspv === 1'b1)
			nrsp++;
	nbi_host i_dut (.mclk_i, .rst_i, .wide_i(wide), .req_valid_i(rv), .req_op_i(op), .req_data_i(wd),
		.addr_column_i(col), .addr_page_i(pg), .addr_block_i(blk), .deselect_i(desel), .guard_i(guard),
		.io_in_i(pin), .ready_busy_n_i(rb_n), .req_ready_o(rdy), .rsp_valid_o(rspv), .rsp_data_o(rsp),
		.chip_select_n_o(cs_n), .command_latch_strobe_o(cle), .address_latch_strobe_o(ale),
		.write_strobe_n_o(we_n), .read_strobe_n_o(read_strobe_n), .write_guard_n_o(wg_n), .io_out_o(io_out),
		.io_oe_o(oe), .busy_o(busy), .status_mode_o(stm));
	nbi_dev_model i_dev (.cs_n, .cle, .ale, .we_n, .read_strobe_n, .oe_h(oe), .io_h(io_out), .busy(dbusy), .pin,
		.rb_n);
	initial begin
		mclk_i = 0;
		forever #25 mclk_i = ~mclk_i;
	end
	task chk(input logic ok, input string m);
		total_checks++;
		if (!ok) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task step(input integer n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// Bounded wait for idle, since a lost request would otherwise hang the run.
	task wait_idle;
		for (int n = 0; n < 40 && rdy !== 1'b1; n++)
			step(1);
		if (rdy !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t request never finished", $time);
		end
	endtask
	task req(input logic [1:0] o, input logic [15:0] d);
		wait_idle;
		op = o;
		wd = d;
		rv = 1;
		step(1);
		rv = 0;
		wait_idle;
	endtask
	task t_cmd;
		wide = 1;
		req(2'h0, 16'hFF70);
		chk(i_dev.cmd === 16'h0070 && stm === 1'b1, "status command");
		req(2'h0, 16'h0000);
		chk(i_dev.cmd === 16'h0000 && stm === 1'b0, "return to data");
	endtask
	task t_addr(input logic w, input logic [11:0] c, input logic [15:0] b0, input logic [15:0] b1);
		wide = w;
		col = c;
		pg = 6'h2A;
		blk = 17'h1A5C3;
		req(2'h0, 16'h0000);
		req(2'h1, 16'h0000);
		chk(i_dev.na === 5 && i_dev.ab[0] === b0 && i_dev.ab[1] === b1, "column bytes");
		chk(i_dev.ab[2] === 16'h00EA && i_dev.ab[3] === 16'h00A5 && i_dev.ab[4] === 16'h0001, "row bytes");
	endtask
	task t_data;
		wide = 1;
		req(2'h2, 16'hBEEF);
		req(2'h3, 16'h0000);
		chk(rsp === 16'hBEEF && nrsp === 1, "read word");
		wide = 0;
		req(2'h2, 16'h12C3);
		req(2'h3, 16'h0000);
		chk(rsp === 16'h00C3 && nrsp === 2, "narrow read word");
	endtask
	task t_pins;
		guard = 0;
		desel = 1;
		dbusy = 1;
		step(6);
		chk(wg_n === 1'b0 && cs_n === 1'b1 && busy === 1'b1, "guard, deselect, busy");
		req(2'h0, 16'h0078);
		chk(i_dev.cmd === 16'h0078 && stm === 1'b1, "status while busy");
		req(2'h1, 16'h0000);
		chk(i_dev.na === 5, "address after die status");
		req(2'h0, 16'h0000);
		chk(i_dev.cmd === 16'h0078 && stm === 1'b0, "busy ignores command");
		dbusy = 0;
		step(6);
		chk(busy === 1'b0, "ready");
	endtask
	task finish_test;
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{rst_i, guard} = 2'h3;
		{wide, rv, desel, dbusy, op, wd, col, pg, blk} = '0;
		step(2);
		rst_i = 0;
		step(1);
		chk(cs_n === 1'b1 && we_n === 1'b1 && read_strobe_n === 1'b1 && oe === 1'b0, "idle after reset");
		t_cmd;
		t_addr(1'b0, 12'h8C5, 16'h0005, 16'h0008);
		t_addr(1'b1, 12'hC25, 16'h0005, 16'h0004);
		t_data;
		t_pins;
		finish_test;
	end
	initial begin
		#100000;
		errors++;
		finish_test;
	end
endmodule
bind nbi_host nbi_host_chk i_chk (.mclk_i, .rst_i, .guard_i, .ready_busy_n_i, .rsp_valid_o, .chip_select_n_o,
	.command_latch_strobe_o, .address_latch_strobe_o, .write_strobe_n_o, .read_strobe_n_o,
	.write_guard_n_o, .io_oe_o, .busy_o, .io_out_o);
`default_nettype wire
